//--- hw/pmcp_top.sv
// code protection permission logic for program flash, eeprom and config
// Operation
// - boot block plus four blocks, each with read, write, cross-read lock
// - block of an address follows from its upper address bits
// - six lock bytes at consecutive addresses, block bits in bits 3..0
// - read-lock bits ignored for cpu, block programmer reads and writes
// - write-lock zero refuses table writes into that block
// - cross-read lock zero still allows reads fetched from same block
// - cross-read lock zero refuses outside reads, returning zero data
// - protection bits only go from one to zero on write
// - only programmer-initiated erase or srst returns protection bits to one
// - eeprom read-lock blocks programmer reads and writes of eeprom
// - eeprom write-lock blocks programmer writes of eeprom
// - cpu reads and writes eeprom regardless of eeprom locks
// - config write lock guards config bytes; cpu may read, not write it
// - eight id locations reachable by table access even when protected
// - debug bit zero enables debugger, driving debugEnable high
// - low-supply bit set plus entry pin high enters programming mode
// - low-supply bit reads one when erased
// - high-voltage entry always possible on master clear pin
`timescale 1ns/1ps
module pmcp_top
	import pmcp_pkg::*;
(
	// clock and reset
	input  wire logic      sys_clk,
	input  wire logic      srst,
	// access request and answer
	input  wire pmcp_req_s req,
	output pmcp_rsp_s      rsp,
	// memory read data returned by arrays
	input  wire logic [7:0] flashRdata,
	input  wire logic [7:0] eepromRdata,
	// programmer erase commands
	input  wire logic      progBulkErase,
	// entry pins
	input  wire logic      progEntryPin,
	input  wire logic      masterClearProgVoltage,
	// mode and status
	output logic           progMode,
	output logic           hvSession,
	output logic           debugEnable,
	output logic           progEntryPinIsGpio,
	output logic           progEntryPullupEnable
);
	typedef struct packed {
		logic [1:0] pinSync;
		logic [1:0] hvSync;
		logic       progMode;
		logic       hvSession;
		logic       allow;
		logic       cfgWrite;
		logic [7:0] rdata;
		logic       cfgRdSel;
	} pmcp_top_s;
	pmcp_top_s st;
	pmcp_top_s next_st;

	logic [CFG_N*8-1:0] cfgBytes;
	logic [7:0]         cfgRd;
	logic [7:0]         rdLockByte;
	logic [7:0]         beRdByte;
	logic [7:0]         wrLockByte;
	logic [7:0]         becWrByte;
	logic [7:0]         xrdLockByte;
	logic [7:0]         bootXrdByte;
	logic [7:0]         dbgLvpByte;
	logic               memWrEn;
	logic [2:0]         memWrIdx;
	logic [2:0]         memRdIdx;
	logic               lvpBit;
	logic               fromProg;

	// debug/lvp byte kept locally, erased to all ones
	logic [7:0] dbgLvp;
	logic [7:0] next_dbgLvp;

	// =========================================================
	// block decoding
	// =========================================================
	function automatic pmcp_blk_e blk_of(input logic [ADDR_W-1:0] a);
		logic [BLK_IDX_W-1:0] idx;
		idx = a[BLK_SH+BLK_IDX_W-1:BLK_SH];
		if (a < BOOT_END) begin
			blk_of = PMCP_BOOT;
		end else if (a < USER_END) begin
			blk_of = pmcp_blk_e'(3'(idx) + 3'(PMCP_B0));
		end else begin
			blk_of = PMCP_NONE;
		end
	endfunction

	function automatic logic lock_of(input pmcp_blk_e b, input logic [7:0] blkByte,
		input logic bootBit);
		if (b == PMCP_BOOT) begin
			lock_of = bootBit;
		end else if (b == PMCP_NONE) begin
			lock_of = 1'b1;
		end else begin
			lock_of = blkByte[3'(b) - 3'(PMCP_B0)];
		end
	endfunction

	function automatic logic is_cfg(input logic [ADDR_W-1:0] a);
		is_cfg = (a >= CFG_BASE) && (a <= CFG_LAST);
	endfunction

	// =========================================================
	// config byte storage
	// =========================================================
	assign rdLockByte  = cfgBytes[0*8 +: 8] & MASK_BLK;
	assign beRdByte    = cfgBytes[1*8 +: 8] & MASK_BE;
	assign wrLockByte  = cfgBytes[2*8 +: 8] & MASK_BLK;
	assign becWrByte   = cfgBytes[3*8 +: 8] & MASK_BEC;
	assign xrdLockByte = cfgBytes[4*8 +: 8] & MASK_BLK;
	assign bootXrdByte = cfgBytes[5*8 +: 8] & MASK_BX;
	assign dbgLvpByte  = dbgLvp & MASK_DL;
	assign lvpBit      = dbgLvp[BIT_LVP];
	assign fromProg    = (req.src == PMCP_SRC_PROG);
	assign memRdIdx    = 3'(req.addr - CFG_RD_LOCK);

	pmcp_cfg_mem #(
		.N(CFG_N)
	) u_mem (
		.sys_clk  (sys_clk),
		.srst     (srst),
		.wrEn     (memWrEn),
		.wrIdx    (memWrIdx),
		.wrData   (req.wdata),
		.eraseAll (progBulkErase && st.progMode),
		.rdIdx    (memRdIdx),
		.rdData   (cfgRd),
		.allBytes (cfgBytes)
	);

	// =========================================================
	// permission decision
	// =========================================================
	logic      allowNow;
	logic      cfgWr;
	pmcp_blk_e tgtBlk;
	pmcp_blk_e fetBlk;
	logic      rdLock;
	logic      wrLock;
	logic      xrdLock;
	logic      cfgLocked;

	always_comb begin
		tgtBlk    = blk_of(req.addr);
		fetBlk    = blk_of(req.fetchAddr);
		rdLock    = lock_of(tgtBlk, rdLockByte, beRdByte[BIT_BOOT_RD]);
		wrLock    = lock_of(tgtBlk, wrLockByte, becWrByte[BIT_BOOT_WR]);
		xrdLock   = lock_of(tgtBlk, xrdLockByte, bootXrdByte[BIT_BOOT_XRD]);
		cfgLocked = !becWrByte[BIT_CFG_WR];
		allowNow  = 1'b0;
		cfgWr     = 1'b0;
		memWrEn   = 1'b0;
		memWrIdx  = memRdIdx;
		next_dbgLvp = dbgLvp;
		if (!req.valid) begin
			allowNow = 1'b0;
		end else if (req.eeprom) begin
			if (!fromProg) begin
				allowNow = 1'b1;
			end else if (!beRdByte[BIT_EE_RD]) begin
				allowNow = 1'b0;
			end else begin
				allowNow = !(req.write && !becWrByte[BIT_EE_WR]);
			end
		end else if (req.addr >= ID_BASE && req.addr <= ID_LAST) begin
			allowNow = 1'b1;
		end else if (is_cfg(req.addr)) begin
			if (!req.write) begin
				allowNow = 1'b1;
			end else if (fromProg) begin
				allowNow = st.progMode;
			end else begin
				allowNow = !cfgLocked && (req.addr != CFG_BEC_WR);
			end
			if (req.write && allowNow) begin
				cfgWr = 1'b1;
				if (req.addr >= CFG_RD_LOCK) begin
					memWrEn = 1'b1;
				end else if (req.addr == CFG_DBG_LVP) begin
					next_dbgLvp = dbgLvp & (req.wdata | (st.hvSession ? ZERO_BYTE
						: (8'h01 << BIT_LVP)));
				end
			end
		end else if (tgtBlk == PMCP_NONE) begin
			allowNow = !req.write;
		end else if (fromProg) begin
			allowNow = st.progMode && rdLock;
		end else if (req.write) begin
			allowNow = wrLock;
		end else begin
			allowNow = xrdLock || (fetBlk == tgtBlk);
		end
		if (progBulkErase && st.progMode) begin
			next_dbgLvp = ERASED;
		end
	end

	// =========================================================
	// programming entry and registered answer
	// =========================================================
	always_comb begin
		next_st          = st;
		next_st.pinSync  = {st.pinSync[0], progEntryPin};
		next_st.hvSync   = {st.hvSync[0], masterClearProgVoltage};
		next_st.hvSession = st.hvSync[1];
		next_st.progMode = st.hvSync[1] || (lvpBit && st.pinSync[1]);
		next_st.allow    = allowNow;
		next_st.cfgWrite = cfgWr;
		next_st.cfgRdSel = 1'b0;
		if (!req.valid || req.write || !allowNow) begin
			next_st.rdata = ZERO_BYTE;
		end else if (req.eeprom) begin
			next_st.rdata = eepromRdata;
		end else if (req.addr == CFG_DBG_LVP) begin
			next_st.rdata = dbgLvpByte;
		end else if (is_cfg(req.addr) && req.addr >= CFG_RD_LOCK) begin
			next_st.rdata    = ZERO_BYTE;
			next_st.cfgRdSel = 1'b1;
		end else begin
			next_st.rdata = flashRdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st.pinSync  <= 2'h0;
			st.hvSync   <= 2'h0;
			st.progMode <= 1'b0;
			st.hvSession <= 1'b0;
			st.allow    <= 1'b0;
			st.cfgWrite <= 1'b0;
			st.rdata    <= ZERO_BYTE;
			st.cfgRdSel <= 1'b0;
			dbgLvp      <= ERASED;
		end else begin
			st     <= next_st;
			dbgLvp <= next_dbgLvp;
		end
	end

	// =========================================================
	// outputs
	// =========================================================
	logic [7:0] cfgMasked;
	always_comb begin
		cfgMasked = cfgRd;
		if (st.cfgRdSel) begin
			cfgMasked = cfgRd;
		end
	end

	assign rsp.allow    = st.allow;
	assign rsp.cfgWrite = st.cfgWrite;
	assign rsp.rdata    = st.cfgRdSel ? cfgMasked : st.rdata;
	assign progMode     = st.progMode;
	assign hvSession    = st.hvSession;
	assign debugEnable  = !dbgLvp[BIT_DEBUG];
	assign progEntryPinIsGpio    = !lvpBit;
	assign progEntryPullupEnable = !lvpBit;
endmodule

//--- hw/pmcp_pkg.sv
// package: protection map, field layout and access carriers
package pmcp_pkg;
	localparam int ADDR_W = 22;
	localparam logic [ADDR_W-1:0] BOOT_END      = 22'h000200;
	localparam logic [ADDR_W-1:0] USER_END      = 22'h008000;
	localparam logic [ADDR_W-1:0] ID_BASE       = 22'h200000;
	localparam logic [ADDR_W-1:0] ID_LAST       = 22'h200007;
	localparam logic [ADDR_W-1:0] CFG_DBG_LVP   = 22'h300006;
	localparam logic [ADDR_W-1:0] CFG_RD_LOCK   = 22'h300008;
	localparam logic [ADDR_W-1:0] CFG_BE_RD     = 22'h300009;
	localparam logic [ADDR_W-1:0] CFG_WR_LOCK   = 22'h30000a;
	localparam logic [ADDR_W-1:0] CFG_BEC_WR    = 22'h30000b;
	localparam logic [ADDR_W-1:0] CFG_XRD_LOCK  = 22'h30000c;
	localparam logic [ADDR_W-1:0] CFG_BOOT_XRD  = 22'h30000d;
	localparam logic [ADDR_W-1:0] CFG_BASE      = 22'h300000;
	localparam logic [ADDR_W-1:0] CFG_LAST      = 22'h30000d;
	localparam int CFG_N  = 6;
	localparam int BLK_SH = 13;
	localparam int BLK_IDX_W = 2;
	localparam int BIT_BOOT_RD  = 6;
	localparam int BIT_EE_RD    = 7;
	localparam int BIT_BOOT_WR  = 6;
	localparam int BIT_CFG_WR   = 5;
	localparam int BIT_EE_WR    = 7;
	localparam int BIT_BOOT_XRD = 6;
	localparam int BIT_DEBUG    = 7;
	localparam int BIT_LVP      = 2;
	localparam logic [7:0] MASK_BLK  = 8'h0f;
	localparam logic [7:0] MASK_BE   = 8'hc0;
	localparam logic [7:0] MASK_BEC  = 8'he0;
	localparam logic [7:0] MASK_BX   = 8'h40;
	localparam logic [7:0] MASK_DL   = 8'h85;
	localparam logic [7:0] ERASED    = 8'hff;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	typedef enum logic [2:0] {
		PMCP_BOOT, PMCP_B0, PMCP_B1, PMCP_B2, PMCP_B3, PMCP_NONE
	} pmcp_blk_e;

	typedef enum logic [1:0] {
		PMCP_SRC_CPU, PMCP_SRC_PROG
	} pmcp_src_e;

	typedef struct packed {
		logic              valid;
		logic              write;
		logic              eeprom;
		pmcp_src_e         src;
		logic [ADDR_W-1:0] addr;
		logic [ADDR_W-1:0] fetchAddr;
		logic [7:0]        wdata;
	} pmcp_req_s;

	typedef struct packed {
		logic       allow;
		logic       cfgWrite;
		logic [7:0] rdata;
	} pmcp_rsp_s;
endpackage

//--- hw/pmcp_cfg_mem.sv
// config byte store with one-way programming and erase
`timescale 1ns/1ps
module pmcp_cfg_mem
	import pmcp_pkg::*;
#(
	parameter int N = CFG_N
) (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             srst,
	// write and erase
	input  wire logic             wrEn,
	input  wire logic [2:0]       wrIdx,
	input  wire logic [7:0]       wrData,
	input  wire logic             eraseAll,
	// read
	input  wire logic [2:0]       rdIdx,
	output logic      [7:0]       rdData,
	output logic      [N*8-1:0]   allBytes
);
	typedef struct packed {
		logic [N-1:0][7:0] mem;
		logic [7:0]        rd;
	} pmcp_mem_s;
	pmcp_mem_s st;
	pmcp_mem_s next_st;

	always_comb begin
		next_st = st;
		for (int i = 0; i < N; i++) begin
			if (eraseAll) begin
				next_st.mem[i] = ERASED;
			end else if (wrEn && wrIdx == 3'(i)) begin
				next_st.mem[i] = st.mem[i] & wrData;
			end
		end
		next_st.rd = (int'(rdIdx) < N) ? next_st.mem[rdIdx] : ZERO_BYTE;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st.mem <= {N{ERASED}};
			st.rd  <= ZERO_BYTE;
		end else begin
			st <= next_st;
		end
	end

	assign rdData   = st.rd;
	assign allBytes = st.mem;
endmodule

//--- tb/pmcp_top_checker.sv
// assertions on the protection block ports
`timescale 1ns/1ps
module pmcp_top_checker
	import pmcp_pkg::*;
(
	// clock and reset
	input wire logic      sys_clk,
	input wire logic      srst,
	// access
	input wire pmcp_req_s req,
	input wire pmcp_rsp_s rsp,
	// mode
	input wire logic      progMode,
	input wire logic      debugEnable,
	input wire logic      progEntryPinIsGpio,
	input wire logic      progEntryPullupEnable
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	wire logic cpu = req.valid && req.src == PMCP_SRC_CPU;
	wire logic prg = req.valid && req.src == PMCP_SRC_PROG;
	zero_on_refuse_a: assert property (!rsp.allow |-> rsp.rdata == ZERO_BYTE)
		else $error("refused access returned data");
	reset_state_a: assert property ($fell(srst) |-> !rsp.allow && !progMode &&
		!debugEnable && !progEntryPinIsGpio) else $error("bad state after reset");
	cfg_wr_guard_a: assert property (cpu && req.write && !req.eeprom && req.addr == CFG_BEC_WR
		|=> !rsp.allow && !rsp.cfgWrite) else $error("cpu wrote config lock byte");
	id_readable_a: assert property (cpu && !req.write && !req.eeprom &&
		req.addr >= ID_BASE && req.addr <= ID_LAST |=> rsp.allow) else $error("id read refused");
	cpu_eeprom_a: assert property (cpu && req.eeprom |=> rsp.allow)
		else $error("cpu eeprom access refused");
	prog_mode_a: assert property (prg && !progMode && !req.eeprom && req.addr < USER_END
		|=> !rsp.allow) else $error("programmer access outside programming mode");
	idle_quiet_a: assert property (!req.valid |=> !rsp.allow && !rsp.cfgWrite)
		else $error("answer without request");
	pullup_gpio_a: assert property (progEntryPullupEnable == progEntryPinIsGpio)
		else $error("pull-up and pin use disagree");
	cfg_write_ok_a: assert property (rsp.cfgWrite |-> rsp.allow)
		else $error("config write while refused");
	lvp_sticky_a: assert property (progEntryPinIsGpio && !progMode |=> progEntryPinIsGpio)
		else $error("low-supply bit set outside programming");
endmodule
bind pmcp_top pmcp_top_checker chk_i (.sys_clk(sys_clk), .srst(srst), .req(req), .rsp(rsp),
	.progMode(progMode), .debugEnable(debugEnable), .progEntryPinIsGpio(progEntryPinIsGpio),
	.progEntryPullupEnable(progEntryPullupEnable));

//--- tb/pmcp_array_model.sv
// flash and eeprom arrays standing behind the protection block
`timescale 1ns/1ps
module pmcp_array_model
	import pmcp_pkg::*;
(
	// request seen by the arrays
	input  wire pmcp_req_s  req,
	// read data
	output logic      [7:0] flashRdata,
	output logic      [7:0] eepromRdata
);
	// data is a pattern of the address; idle arrays show its inverse
	always_comb begin
		flashRdata  = req.addr[7:0] ^ 8'h3c;
		eepromRdata = req.addr[7:0] ^ 8'hc3;
		if (!req.valid) begin
			flashRdata  = ~flashRdata;
			eepromRdata = ~eepromRdata;
		end
	end
endmodule

//--- tb/tb_pmcp_top.sv
// testbench for the code protection block
`timescale 1ns/1ps
module tb_pmcp_top;
	import pmcp_pkg::*;
	logic       sys_clk;
	logic       srst;
	pmcp_req_s  req;
	pmcp_rsp_s  rsp;
	logic [7:0] flashRdata;
	logic [7:0] eepromRdata;
	logic       progBulkErase;
	logic       progEntryPin;
	logic       masterClearProgVoltage;
	logic       progMode;
	logic       hvSession;
	logic       debugEnable;
	logic       progEntryPinIsGpio;
	logic       progEntryPullupEnable;
	logic       rAllow;
	logic       rCfg;
	logic [7:0] rData;
	int         failures;
	int         total_checks;
	pmcp_top dut (.sys_clk(sys_clk), .srst(srst), .req(req), .rsp(rsp),
		.flashRdata(flashRdata), .eepromRdata(eepromRdata), .progBulkErase(progBulkErase),
		.progEntryPin(progEntryPin), .masterClearProgVoltage(masterClearProgVoltage),
		.progMode(progMode), .hvSession(hvSession), .debugEnable(debugEnable),
		.progEntryPinIsGpio(progEntryPinIsGpio), .progEntryPullupEnable(progEntryPullupEnable));
	pmcp_array_model arr (.req(req), .flashRdata(flashRdata), .eepromRdata(eepromRdata));
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// ==========
	// shared tasks
	task automatic results();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one request, answer taken a cycle later, then one idle cycle
	task automatic acc(input pmcp_src_e s, input logic w, input logic e,
		input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] f, input logic [7:0] d);
		req <= '{1'b1, w, e, s, a, f, d};
		@(negedge sys_clk);
		rAllow = rsp.allow;
		rCfg = rsp.cfgWrite;
		rData = rsp.rdata;
		req.valid <= 1'b0;
		@(negedge sys_clk);
	endtask
	task automatic waitMode(input logic v);
		int n;
		n = 0;
		while (progMode !== v && n < 10) begin
			@(negedge sys_clk);
			n++;
		end
		chk(8'(progMode), 8'(v));
		if (progMode !== v) begin
			results();
		end
	endtask
	// ==========
	// scenarios
	task automatic t_reset();
		chk(8'(rsp.allow), 8'h00);
		chk(8'(debugEnable), 8'h00);
		chk(8'(progEntryPinIsGpio), 8'h00);
		acc(PMCP_SRC_CPU, 1'b0, 1'b0, CFG_RD_LOCK, 22'h0, 8'h00);
		chk(rData & MASK_BLK, MASK_BLK);
		acc(PMCP_SRC_CPU, 1'b0, 1'b0, CFG_DBG_LVP, 22'h0, 8'h00);
		chk(8'(rData[BIT_LVP]), 8'h01);
		acc(PMCP_SRC_PROG, 1'b0, 1'b0, 22'h000100, 22'h0, 8'h00);
		chk(8'(rAllow), 8'h00);
		acc(PMCP_SRC_CPU, 1'b0, 1'b0, ID_LAST, 22'h0, 8'h00);
		chk(8'(rAllow), 8'h01);
	endtask
	task automatic t_entry();
		progEntryPin = 1'b1;
		waitMode(1'b1);
		progEntryPin = 1'b0;
		waitMode(1'b0);
		masterClearProgVoltage = 1'b1;
		waitMode(1'b1);
		chk(8'(hvSession), 8'h01);
	endtask
	task automatic t_locks();
		acc(PMCP_SRC_PROG, 1'b1, 1'b0, CFG_XRD_LOCK, 22'h0, 8'hfd);
		chk(8'(rCfg), 8'h01);
		acc(PMCP_SRC_PROG, 1'b1, 1'b0, CFG_WR_LOCK, 22'h0, 8'hfe);
		acc(PMCP_SRC_PROG, 1'b1, 1'b0, CFG_BE_RD, 22'h0, 8'h7f);
		acc(PMCP_SRC_PROG, 1'b1, 1'b0, CFG_RD_LOCK, 22'h0, 8'hfb);
		acc(PMCP_SRC_PROG, 1'b0, 1'b0, 22'h002100, 22'h0, 8'h00);
		chk(rData, 8'h3c);
		acc(PMCP_SRC_PROG, 1'b0, 1'b0, 22'h004100, 22'h0, 8'h00);
		chk(8'(rAllow), 8'h00);
		acc(PMCP_SRC_PROG, 1'b0, 1'b1, 22'h0, 22'h0, 8'h00);
		chk(8'(rAllow), 8'h00);
		acc(PMCP_SRC_PROG, 1'b1, 1'b0, CFG_XRD_LOCK, 22'h0, 8'hff);
		acc(PMCP_SRC_PROG, 1'b0, 1'b0, CFG_XRD_LOCK, 22'h0, 8'h00);
		chk(8'(rData[1]), 8'h00);
		masterClearProgVoltage = 1'b0;
		waitMode(1'b0);
	endtask
	task automatic t_cpu();
		acc(PMCP_SRC_CPU, 1'b0, 1'b0, 22'h002100, 22'h000100, 8'h00);
		chk(8'(rAllow), 8'h00);
		chk(rData, 8'h00);
		acc(PMCP_SRC_CPU, 1'b0, 1'b0, 22'h002100, 22'h002200, 8'h00);
		chk(rData, 8'h3c);
		acc(PMCP_SRC_CPU, 1'b1, 1'b0, 22'h000300, 22'h000100, 8'h00);
		chk(8'(rAllow), 8'h00);
		acc(PMCP_SRC_CPU, 1'b1, 1'b0, 22'h002300, 22'h000100, 8'h00);
		chk(8'(rAllow), 8'h01);
		acc(PMCP_SRC_CPU, 1'b0, 1'b0, 22'h004100, 22'h000100, 8'h00);
		chk(rData, 8'h3c);
		acc(PMCP_SRC_CPU, 1'b0, 1'b1, 22'h0, 22'h000100, 8'h00);
		chk(rData, 8'hc3);
		acc(PMCP_SRC_CPU, 1'b1, 1'b0, CFG_BEC_WR, 22'h000100, 8'h00);
		chk(8'(rAllow), 8'h00);
	endtask
	task automatic t_erase();
		masterClearProgVoltage = 1'b1;
		waitMode(1'b1);
		progBulkErase = 1'b1;
		@(negedge sys_clk);
		progBulkErase = 1'b0;
		@(negedge sys_clk);
		acc(PMCP_SRC_PROG, 1'b0, 1'b0, CFG_XRD_LOCK, 22'h0, 8'h00);
		chk(8'(rData[1]), 8'h01);
		acc(PMCP_SRC_PROG, 1'b1, 1'b0, CFG_BEC_WR, 22'h0, 8'h7f);
		chk(8'(rCfg), 8'h01);
		acc(PMCP_SRC_PROG, 1'b0, 1'b1, 22'h0, 22'h0, 8'h00);
		chk(rData, 8'hc3);
		acc(PMCP_SRC_PROG, 1'b1, 1'b1, 22'h0, 22'h0, 8'h00);
		chk(8'(rAllow), 8'h00);
		acc(PMCP_SRC_CPU, 1'b1, 1'b1, 22'h0, 22'h000100, 8'h00);
		chk(8'(rAllow), 8'h01);
		acc(PMCP_SRC_PROG, 1'b1, 1'b0, CFG_DBG_LVP, 22'h0, 8'h7b);
		chk(8'(debugEnable), 8'h01);
		chk(8'(progEntryPullupEnable), 8'h01);
		chk(8'(progEntryPinIsGpio), 8'h01);
		masterClearProgVoltage = 1'b0;
		waitMode(1'b0);
		progEntryPin = 1'b1;
		repeat (6) @(negedge sys_clk);
		chk(8'(progMode), 8'h00);
		progEntryPin = 1'b0;
		masterClearProgVoltage = 1'b1;
		waitMode(1'b1);
		masterClearProgVoltage = 1'b0;
		waitMode(1'b0);
	endtask
	initial begin
		failures = 0;
		total_checks = 0;
		srst = 1'b1;
		req = '0;
		progBulkErase = 1'b0;
		progEntryPin = 1'b0;
		masterClearProgVoltage = 1'b0;
		repeat (16) @(negedge sys_clk);
		srst = 1'b0;
		@(negedge sys_clk);
		t_reset();
		t_entry();
		t_locks();
		t_cpu();
		t_erase();
		results();
	end
endmodule
